// ==== rtl/cst_pkg.sv ====
package cst_pkg;
  // master timing clock: one period of the sequence, in mclk cycles
  localparam int MCLK_NS_X10     = 40;   // 4 ns clock period, in 0.1 ns
  localparam int PERIOD_NS_X10   = 2375; // 237.5 ns master period
  localparam int PERIOD_CYC      = PERIOD_NS_X10 / MCLK_NS_X10;
  localparam int DRY_TRAP_NS     = 170;  // shortened data ready width
  localparam int DRY_TRAP_CYC    = (DRY_TRAP_NS * 10) / MCLK_NS_X10;
  localparam int DRY_NORM_CYC    = PERIOD_NS_X10 / MCLK_NS_X10;
  // sampling clock 0.58 MHz: half period about 862 ns
  localparam int SAMP_HALF_NS    = 862;
  localparam int SAMP_HALF_CYC   = (SAMP_HALF_NS * 10) / MCLK_NS_X10;
  localparam int WORD_W          = 16;   // bus word width
  localparam logic [3:0] PER_LAST = 4'h8; // eight periods per sequence

  typedef enum logic [1:0] {
    CST_IDLE = 2'b00,
    CST_INTR = 2'b01,
    CST_TOUT = 2'b10,
    CST_TIN  = 2'b11
  } cst_op_t;

  // near-side processor status inputs
  typedef struct packed {
    logic phase_timing_clock;
    logic fetch_cycle_flag;
    logic execute_phase_flag;
    logic intr_inhibit;
    logic trap_inhibit;
    logic two_word_op;
    logic jump_and_mark_op;
  } cst_cpu_t;

  // datapath and memory controls driven toward the processor
  typedef struct packed {
    logic arith_clear_receive;
    logic address_receive_window;
    logic io_bus_receive_gate;
    logic load_address_register;
    logic address_increment;
    logic arith_bus_select;
    logic phase_clock_enable;
    logic clock_one_inhibit;
    logic clear_word_register;
    logic memory_start_pulse;
    logic load_instr_register;
    logic trap_output_gate;
    logic io_bus_drive_gate;
    logic trap_input_gate;
    logic half_cycle_select;
    logic trap_write_latch;
    logic load_word_register;
  } cst_ctl_t;
endpackage

// ==== rtl/cst_timer.sv ====
`timescale 1ns/1ps
// divider giving a one-cycle enable at a fixed count
module cst_timer #(
  parameter int COUNT = cst_pkg::PERIOD_CYC
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic run,   // hold at zero while low
  output logic      tick   // one-cycle pulse every COUNT cycles
);
  logic [15:0] cnt_q;      // running count

  // count up, wrap and pulse at the terminal value
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (cnt_q == 16'(COUNT - 1)) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick  <= 1'b0;
    end
  end
endmodule

// ==== rtl/cst_sequencer.sv ====
`timescale 1ns/1ps
//Contract
//- interrupt detected at phase low and fetch
//- trap detected at phase high and execute
//- interrupt period 2 sets inhibit, acknowledge
//- interrupt period 3 timing one, address load
//- interrupt function ready at period 4, unused
//- interrupt period 5 timing two, memory start
//- period 7 loads instruction, timing one again
//- two-word op forces address bit zero
//- jump-and-mark issues jump signal in period 8
//- trap holds acknowledge through period 7, inhibit through period 8
//- trap period 3 sets release, timing one
//- trap-out period 4 clears word, reads memory
//- trap-out period 5 drives word onto bus
//- trap-out data ready shortened to 170 ns
//- trap-out period 8 resets, inhibit ends after
//- trap-in starts exactly like trap-out
//- trap-in period 4 function ready, dummy cycle
//- trap-in period 5 half cycle, bus receive
//- trap-in period 6 sets write latch
//- trap-in period 7 loads word, starts write
//- trap-in period 8 resets latch and gates
//- sampling clock 0.58 MHz, held during acknowledge
module cst_sequencer
  import cst_pkg::*;
#(
  parameter int PER_CYC = cst_pkg::PERIOD_CYC
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                interrupt_request_line,
  input  wire logic                trap_out_request,
  input  wire logic                trap_in_request,
  input  wire cst_pkg::cst_cpu_t   cpu_in,
  input  wire logic [cst_pkg::WORD_W-1:0] io_bus_in,
  input  wire logic [cst_pkg::WORD_W-1:0] mem_word_in,
  output logic                     acknowledge_ff,
  output logic                     request_sampling_clock,
  output logic                     jump_mark_inhibit,
  output logic                     function_ready_strobe,
  output logic                     data_ready_strobe,
  output logic [cst_pkg::WORD_W-1:0] io_bus_out,
  output logic                     io_bus_oe,
  output logic [cst_pkg::WORD_W-1:0] mem_addr_out,
  output logic [cst_pkg::WORD_W-1:0] mem_data_out,
  output cst_pkg::cst_ctl_t        ctl,
  output logic                     clock_inhibit_ff,
  output logic                     busy
);
  import cst_pkg::*;

  // synchronised pins and processor flags
  logic [2:0] req_s1_q;                  // first stage, read only by stage 2
  logic [2:0] req_s2_q;                  // usable request levels
  cst_cpu_t   cpu_q;                     // same-domain status, no sync
  logic [WORD_W-1:0] bus_s1_q;           // bus first stage
  logic [WORD_W-1:0] bus_s2_q;           // bus usable value

  // sequencer state
  cst_op_t    op_q;                      // running operation
  logic [3:0] per_q;                     // current master period 1..8
  logic       per_tick;                  // end of a master period
  logic [7:0] sub_q;                     // cycle within the period
  logic       ack_rel_q;                 // acknowledge release flip-flop
  logic       t1_q;                      // sequence timing one
  logic       t2_q;                      // sequence timing two
  logic       wlatch_q;                  // trap write latch
  logic       samp_tick;                 // sampling clock half period
  logic       samp_q;                    // free-running sampling clock
  logic [7:0] dry_cnt_q;                 // data ready width counter
  logic       trap_op;                   // either trap kind

  // trap request inside its phase and execute window, not inhibited
  function automatic logic trap_hit(input logic [2:0] r,
                                    input cst_cpu_t   c);
    return (r[1] || r[2]) && c.phase_timing_clock &&
           c.execute_phase_flag && !c.trap_inhibit;
  endfunction

  // interrupt request inside its phase-low fetch window, not inhibited
  function automatic logic intr_hit(input logic [2:0] r,
                                    input cst_cpu_t   c);
    return r[0] && !c.phase_timing_clock && c.fetch_cycle_flag &&
           !c.intr_inhibit;
  endfunction

  assign trap_op = (op_q == CST_TOUT) || (op_q == CST_TIN);

  // master period divider, held while idle
  cst_timer #(.COUNT(PER_CYC)) u_per (
    .mclk (mclk),
    .rst  (rst),
    .run  (op_q != CST_IDLE),
    .tick (per_tick)
  );

  // sampling clock divider, free running
  cst_timer #(.COUNT(SAMP_HALF_CYC)) u_samp (
    .mclk (mclk),
    .rst  (rst),
    .run  (1'b1),
    .tick (samp_tick)
  );

  // two-stage synchronisers for pin inputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      req_s1_q <= 3'h0;
      req_s2_q <= 3'h0;
      bus_s1_q <= '0;
      bus_s2_q <= '0;
    end else begin
      req_s1_q <= {trap_in_request, trap_out_request,
                   interrupt_request_line};
      req_s2_q <= req_s1_q;
      bus_s1_q <= io_bus_in;
      bus_s2_q <= bus_s1_q;
    end
  end

  // processor flags come from the same clock
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) cpu_q <= '0;
    else     cpu_q <= cpu_in;
  end

  // operation select, detection and sequence end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      op_q             <= CST_IDLE;
      per_q            <= 4'h1;
      clock_inhibit_ff <= 1'b0;
    end else if (op_q == CST_IDLE) begin
      per_q <= 4'h1;
      // new request only once inhibit has reset
      if (trap_hit(req_s2_q, cpu_q)) begin
        // trap-out wins a tie; both trap kinds start alike
        op_q             <= req_s2_q[1] ? CST_TOUT : CST_TIN;
        per_q            <= 4'h2;
        clock_inhibit_ff <= 1'b1;
      end else if (intr_hit(req_s2_q, cpu_q)) begin
        op_q             <= CST_INTR;
        per_q            <= 4'h2;
        clock_inhibit_ff <= 1'b1;
      end
    end else if (per_tick) begin
      if (per_q == PER_LAST) begin
        op_q             <= CST_IDLE;
        clock_inhibit_ff <= 1'b0;
      end else begin
        per_q <= per_q + 4'h1;
        // interrupt drops inhibit entering period 3
        if (op_q == CST_INTR && per_q == 4'h2)
          clock_inhibit_ff <= 1'b0;
      end
    end
  end

  // acknowledge and release flip-flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acknowledge_ff <= 1'b0;
      ack_rel_q      <= 1'b0;
    end else if (op_q == CST_IDLE) begin
      acknowledge_ff <= 1'b0;
      ack_rel_q      <= 1'b0;
      // set together with inhibit
      if (trap_hit(req_s2_q, cpu_q) || intr_hit(req_s2_q, cpu_q))
        acknowledge_ff <= 1'b1;
    end else if (per_tick) begin
      if (op_q == CST_INTR && per_q == 4'h2)
        acknowledge_ff <= 1'b0;
      if (trap_op && per_q == 4'h2)
        ack_rel_q <= 1'b1;
      // release lets acknowledge drop while inhibit still stands
      if (trap_op && per_q == 4'h7 && ack_rel_q)
        acknowledge_ff <= 1'b0;
    end
  end

  // timing flip-flops and write latch, moved at period starts
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      t1_q     <= 1'b0;
      t2_q     <= 1'b0;
      wlatch_q <= 1'b0;
    end else if (op_q == CST_IDLE) begin
      t1_q     <= 1'b0;
      t2_q     <= 1'b0;
      wlatch_q <= 1'b0;
    end else if (per_tick) begin
      unique case (per_q)
        4'h2: t1_q <= 1'b1;
        4'h4: begin
          t1_q <= 1'b0;
          t2_q <= 1'b1;
        end
        4'h5: begin
          if (trap_op) t1_q <= 1'b1;
          // write latch opens with period 6 on trap-in
          if (op_q == CST_TIN) wlatch_q <= 1'b1;
        end
        4'h6: if (op_q == CST_INTR) t1_q <= 1'b1;
        4'h7: if (trap_op) begin
          t1_q     <= 1'b0;
          t2_q     <= 1'b0;
          wlatch_q <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // period-relative position, drives pulse widths
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)                           sub_q <= 8'h00;
    else if (op_q == CST_IDLE || per_tick) sub_q <= 8'h00;
    else if (sub_q != 8'hff)           sub_q <= sub_q + 8'h01;
  end

  // sampling clock; held true through acknowledge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      samp_q                 <= 1'b0;
      request_sampling_clock <= 1'b0;
    end else begin
      if (samp_tick) samp_q <= ~samp_q;
      request_sampling_clock <= acknowledge_ff | samp_q;
    end
  end

  // strobes toward controllers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      function_ready_strobe <= 1'b0;
      data_ready_strobe     <= 1'b0;
      jump_mark_inhibit     <= 1'b0;
      dry_cnt_q             <= 8'h00;
    end else begin
      // function ready in period 4; unused by interrupts
      function_ready_strobe <= (op_q != CST_IDLE) && per_q == 4'h4;
      // jump signal during period 8 for jump-and-mark
      jump_mark_inhibit <= op_q == CST_INTR && per_q == PER_LAST &&
                           cpu_q.two_word_op && cpu_q.jump_and_mark_op;
      // data ready: 170 ns on trap-out, full period on trap-in
      if (trap_op && per_q == 4'h7 && sub_q == 8'h00 && !per_tick)
        dry_cnt_q <= (op_q == CST_TOUT) ? 8'(DRY_TRAP_CYC)
                                        : 8'(DRY_NORM_CYC);
      else if (dry_cnt_q != 8'h00)
        dry_cnt_q <= dry_cnt_q - 8'h01;
      // controller drops its request after this falls
      data_ready_strobe <= dry_cnt_q != 8'h00;
    end
  end

  // datapath and memory controls
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl <= '0;
    end else begin
      ctl.arith_bus_select   <= trap_op;
      ctl.clock_one_inhibit  <= clock_inhibit_ff;
      ctl.address_receive_window <= t1_q && !t2_q &&
                                    per_q <= 4'h4;
      ctl.phase_clock_enable <= trap_op && t1_q;
      ctl.address_increment  <= op_q == CST_INTR && per_q == PER_LAST &&
                                cpu_q.two_word_op;
      ctl.arith_clear_receive <= (t1_q && per_q <= 4'h4) || (trap_op && t2_q)
                                 || ctl.address_increment;
      ctl.io_bus_receive_gate <= (t1_q && per_q <= 4'h4) ||
                                 (op_q == CST_TIN && t2_q) ||
                                 ctl.address_increment;
      ctl.load_address_register <= (t1_q && per_q <= 4'h4) ||
          (ctl.address_increment && per_tick);
      ctl.trap_output_gate  <= op_q == CST_TOUT && t2_q;
      ctl.io_bus_drive_gate <= op_q == CST_TOUT && t2_q;
      ctl.trap_input_gate   <= op_q == CST_TIN && t2_q;
      ctl.half_cycle_select <= op_q == CST_TIN && t2_q;
      ctl.trap_write_latch  <= wlatch_q;
      ctl.clear_word_register <= trap_op && per_q == 4'h4 &&
                                 sub_q == 8'h00;
      ctl.memory_start_pulse <= (per_tick && per_q == 4'h4 && op_q == CST_INTR)
          || (trap_op && per_q == 4'h4 && sub_q == 8'h00)
          || (op_q == CST_TIN && per_q == 4'h7 && sub_q == 8'h00);
      ctl.load_word_register <= op_q == CST_TIN && per_q == 4'h7 &&
                                sub_q == 8'h00;
      ctl.load_instr_register <= op_q == CST_INTR && per_tick &&
                                 per_q == 4'h6;
    end
  end

  // address and data words
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem_addr_out <= '0;
      mem_data_out <= '0;
      io_bus_out   <= '0;
      io_bus_oe    <= 1'b0;
      busy         <= 1'b0;
    end else begin
      busy <= op_q != CST_IDLE;
      // capture address while the receive window is open
      if (t1_q && per_q <= 4'h4)
        mem_addr_out <= bus_s2_q;
      // second word: bit 0 forced, controller address is even
      else if (op_q == CST_INTR && per_q == PER_LAST && per_tick &&
               cpu_q.two_word_op)
        mem_addr_out <= bus_s2_q | 16'h0001;
      if (op_q == CST_TIN && per_q == 4'h7 && sub_q == 8'h00)
        mem_data_out <= bus_s2_q;
      // bus driven from periods 5 to 7 on trap-out
      io_bus_oe  <= op_q == CST_TOUT && t2_q;
      io_bus_out <= (op_q == CST_TOUT && t2_q) ? mem_word_in : '0;
    end
  end
endmodule

// ==== sim/cst_chk.sv ====
`timescale 1ns/1ps
// port-level timing checks for the cycle-steal sequencer
module cst_chk
  import cst_pkg::*;
#(
  parameter int PER_CYC = cst_pkg::PERIOD_CYC
) (
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              acknowledge_ff,
  input wire logic              request_sampling_clock,
  input wire logic              jump_mark_inhibit,
  input wire logic              function_ready_strobe,
  input wire logic              data_ready_strobe,
  input wire logic              io_bus_oe,
  input wire cst_pkg::cst_ctl_t ctl,
  input wire logic              clock_inhibit_ff,
  input wire logic              busy
);
  localparam int INH_MAX = 8 * PER_CYC + 2; // one sequence plus lag
  localparam int GAP_LO  = 2 * PER_CYC - 4; // drive start to data ready
  localparam int GAP_HI  = 3 * PER_CYC;
  logic [9:0] dry_q; // cycles data ready has stood
  logic [9:0] inh_q; // cycles inhibit has stood
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // width of the current data ready pulse
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) dry_q <= '0;
    else dry_q <= data_ready_strobe ? dry_q + 10'h001 : 10'h000;
  end
  // length of the current inhibit, catches a sequence that never ends
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) inh_q <= '0;
    else inh_q <= clock_inhibit_ff ? inh_q + 10'h001 : 10'h000;
  end
  property p_ack_inh; $rose(clock_inhibit_ff) |-> $rose(acknowledge_ff);
  endproperty
  a_ack_inh: assert property (p_ack_inh) else $error("ack late");
  property p_samp_hold;
    acknowledge_ff && $past(acknowledge_ff) |-> request_sampling_clock;
  endproperty
  a_samp_hold: assert property (p_samp_hold) else $error("samp low");
  property p_dry_out;
    $fell(data_ready_strobe) && $past(io_bus_oe) |-> dry_q == DRY_TRAP_CYC;
  endproperty
  a_dry_out: assert property (p_dry_out) else $error("dry width");
  // only traps make data ready; no bus drive before its fall means trap-in
  property p_dry_in; $fell(data_ready_strobe) && !$past(io_bus_oe)
    |-> dry_q == DRY_NORM_CYC; endproperty
  a_dry_in: assert property (p_dry_in) else $error("dry width in");
  property p_oe_inh; io_bus_oe |-> clock_inhibit_ff && !ctl.trap_write_latch;
  endproperty
  a_oe_inh: assert property (p_oe_inh) else $error("stray drive");
  property p_oe_dry;
    $rose(io_bus_oe) |-> ##[GAP_LO:GAP_HI] $rose(data_ready_strobe);
  endproperty
  a_oe_dry: assert property (p_oe_dry) else $error("no data ready");
  property p_trap_sel;
    io_bus_oe |-> ctl.arith_bus_select && ctl.clock_one_inhibit;
  endproperty
  a_trap_sel: assert property (p_trap_sel) else $error("bus select");
  property p_inh_len; inh_q <= INH_MAX; endproperty
  a_inh_len: assert property (p_inh_len) else $error("inhibit stuck");
  property p_jump; jump_mark_inhibit |-> busy && !acknowledge_ff && !io_bus_oe;
  endproperty
  a_jump: assert property (p_jump) else $error("stray jump");
  property p_fry; function_ready_strobe |-> busy && !data_ready_strobe;
  endproperty
  a_fry: assert property (p_fry) else $error("stray ready");
  property p_rst; $fell(rst) |-> !acknowledge_ff && !clock_inhibit_ff && !busy;
  endproperty
  a_rst: assert property (p_rst) else $error("reset left state");
endmodule

bind cst_sequencer cst_chk #(.PER_CYC(PER_CYC)) cst_chk_inst (
  .mclk, .rst, .acknowledge_ff, .request_sampling_clock, .jump_mark_inhibit,
  .function_ready_strobe, .data_ready_strobe, .io_bus_oe, .ctl,
  .clock_inhibit_ff, .busy
);

// ==== sim/cst_ctrl_model.sv ====
`timescale 1ns/1ps
// behavioural peripheral controller: one request per enable
module cst_ctrl_model
  import cst_pkg::*;
(
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire logic                       go,
  input  wire cst_pkg::cst_op_t           kind,
  input  wire logic [cst_pkg::WORD_W-1:0] addr,
  input  wire logic [cst_pkg::WORD_W-1:0] data,
  input  wire logic                       samp,
  input  wire logic                       ack,
  input  wire logic                       fry,
  input  wire logic                       dry,
  input  wire logic [cst_pkg::WORD_W-1:0] bus_out,
  output logic [2:0]                      req,
  output logic [cst_pkg::WORD_W-1:0]      bus_in,
  output logic [cst_pkg::WORD_W-1:0]      got
);
  initial begin
    req = 3'b000;
    bus_in = '0;
    got = '0;
  end
  // request, address, data handoff; released lines flip, never hold stale
  always begin : flow
    @(posedge mclk iff go);
    @(negedge samp);
    @(posedge mclk);
    #1 req = (kind == CST_INTR) ? 3'b100 : (kind == CST_TOUT) ? 3'b010 : 3'b001;
    @(posedge mclk iff ack);
    #1 bus_in = addr; // caller keeps it even
    if (kind == CST_INTR) begin
      req = 3'b000;
    end else begin
      @(posedge mclk iff fry);
      @(posedge mclk iff !fry);
      #1 bus_in = (kind == CST_TIN) ? data : ~addr;
      @(posedge mclk iff dry);
      @(posedge mclk iff !dry);
      got = bus_out;
      @(posedge mclk iff !ack);
      #1 req = 3'b000;
      bus_in = ~bus_in;
    end
    @(posedge mclk iff !go);
    #1 bus_in = ~bus_in;
  end
  // a reset abandons the transfer in progress
  always @(posedge rst) begin
    disable flow;
    req <= 3'b000;
  end
endmodule

// ==== sim/tb_cycle_steal_interrupt_sequencer.sv ====
`timescale 1ns/1ps
// directed bench: the sequencer faces a behavioural controller model
module tb_cycle_steal_interrupt_sequencer;
  import cst_pkg::*;
  logic              mclk, rst, go;
  logic [2:0]        req;      // interrupt, trap-out, trap-in pins
  cst_cpu_t          cpu;      // processor status flags
  logic [WORD_W-1:0] bus_in, mem_word, bus_out, maddr, mdata, addr, data, got;
  logic              ack, samp, jmp, fry, dry, oe, inh, busy;
  cst_ctl_t          ctl;
  cst_op_t           kind;
  logic [7:0]        seen;     // sticky strobe history of a scenario
  int                dry_n, dry_w, n_mismatch, total_checks;
  cst_sequencer #(.PER_CYC(PERIOD_CYC)) cst_sequencer_inst (
    .mclk(mclk), .rst(rst), .interrupt_request_line(req[2]),
    .trap_out_request(req[1]), .trap_in_request(req[0]), .cpu_in(cpu),
    .io_bus_in(bus_in), .mem_word_in(mem_word), .acknowledge_ff(ack),
    .request_sampling_clock(samp), .jump_mark_inhibit(jmp),
    .function_ready_strobe(fry), .data_ready_strobe(dry),
    .io_bus_out(bus_out), .io_bus_oe(oe), .mem_addr_out(maddr),
    .mem_data_out(mdata), .ctl(ctl), .clock_inhibit_ff(inh), .busy(busy));
  cst_ctrl_model cst_ctrl_model_inst (
    .mclk(mclk), .rst(rst), .go(go), .kind(kind), .addr(addr),
    .data(data), .samp(samp), .ack(ack), .fry(fry), .dry(dry),
    .bus_out(bus_out), .req(req), .bus_in(bus_in), .got(got));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // strobes are short, so record them as they pass
  always @(posedge mclk) begin
    seen <= seen | {oe, jmp, fry, ctl.memory_start_pulse,
      ctl.load_instr_register, ctl.trap_write_latch,
      ctl.half_cycle_select, ctl.load_word_register};
    dry_n <= dry ? dry_n + 1 : 0;
    if (!dry && dry_n != 0) dry_w <= dry_n;
  end
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // bounded wait: 0 for acknowledge, 1 for sequencer idle
  task automatic wait_for(input int w);
    int i;
    for (i = 0; i < 2000; i++) begin
      @(posedge mclk);
      if (w == 0 ? ack === 1'b1 : (busy === 1'b0 && inh === 1'b0)) break;
    end
    if (i == 2000) begin
      n_mismatch++;
      $display("[FAIL] %0t wait timed out", $time);
      summarize();
    end
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic start(input cst_op_t k, input logic [15:0] a, d,
                       input logic [6:0] f);
    @(posedge mclk);
    #1 cpu = cst_cpu_t'(f);
    kind = k;
    addr = a;
    data = d;
    seen = '0;
    go = 1'b1;
  endtask
  task automatic trap_out_s(input logic [15:0] a, w);
    start(CST_TOUT, a, 16'h0000, 7'b1010100);
    mem_word = w;
    repeat (700) @(posedge mclk);
    chk(ack === 1'b0, "trap taken while inhibited");
    #1 cpu.trap_inhibit = 1'b0;
    wait_for(0);
    chk(inh === 1'b1, "inhibit not set with ack");
    wait_for(1);
    chk(got === w, "trap-out word wrong");
    chk(maddr === a, "trap address lost");
    chk(seen[7] && seen[5] && seen[4], "drive or start missing");
    chk(dry_w == DRY_TRAP_CYC, "trap-out data ready width");
    chk(seen[2] === 1'b0, "write latch in trap-out");
    go = 1'b0;
  endtask
  task automatic trap_in_s(input logic [15:0] a, d);
    start(CST_TIN, a, d, 7'b1010000);
    wait_for(0);
    chk(samp === 1'b1, "sampling clock not held");
    wait_for(1);
    chk(mdata === d, "trap-in word not stored");
    chk(maddr === a, "trap-in address lost");
    chk(seen[2] && seen[1] && seen[0], "write controls missing");
    chk(seen[7] === 1'b0, "bus driven in trap-in");
    chk(dry_w == DRY_NORM_CYC, "trap-in data ready width");
    go = 1'b0;
  endtask
  task automatic intr_s(input logic [15:0] a, input logic [6:0] f);
    start(CST_INTR, a, 16'h0000, f);
    wait_for(0);
    wait_for(1);
    chk(maddr === (f[1] ? (a | 16'h0001) : a), "interrupt address");
    chk(seen[6] === (f[1] & f[0]), "jump signal");
    chk(seen[5] && seen[4] && seen[3], "fetch steps missing");
    chk(seen[7] === 1'b0, "bus driven in interrupt");
    go = 1'b0;
  endtask
  task automatic samp_s;
    logic s0;
    int   n, i;
    n = 0;
    @(posedge mclk);
    s0 = samp;
    for (i = 0; i < 500 && samp === s0; i++) @(posedge mclk);
    s0 = samp;
    for (i = 0; i < 500 && samp === s0; i++) begin
      @(posedge mclk);
      n++;
    end
    chk(n >= SAMP_HALF_CYC - 1 && n <= SAMP_HALF_CYC + 1, "samp rate");
  endtask
  task automatic rst_s;
    start(CST_TOUT, 16'h0a40, 16'h0000, 7'b1010000);
    wait_for(0);
    repeat (100) @(posedge mclk);
    #1 rst = 1'b1;
    go = 1'b0;
    repeat (5) @(posedge mclk);
    chk((ack | inh | busy | oe) === 1'b0, "reset left sequence");
    #1 rst = 1'b0;
  endtask
  initial begin
    rst = 1'b1;
    go = 1'b0;
    kind = CST_IDLE;
    addr = '0;
    data = '0;
    mem_word = '0;
    cpu = '0;
    seen = '0;
    dry_n = 0;
    dry_w = 0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (5) @(posedge mclk);
    #1 rst = 1'b0;
    samp_s();
    trap_out_s(16'h0a5a, 16'h5555);
    trap_in_s(16'h1234, 16'hc3a5);
    trap_out_s(16'h7ffe, 16'haaaa);
    intr_s(16'h0200, 7'b0100000);
    intr_s(16'h0310, 7'b0100010);
    intr_s(16'h03fe, 7'b0100011);
    rst_s();
    trap_in_s(16'hfffe, 16'h0001);
    summarize();
  end
endmodule
